// ### hw/cmr_core.sv
// Executor for store, load, idle and the three return instructions of the core.
// It decodes one 14-bit word per cycle, updates the accumulator and program counter,
// raises a one-cycle file write for a store and pops the return stack for a return.
// Assumes one instruction word offered per cycle while instr_ready is high,
// and a stack that presents stack_top combinationally and pops on stack_pop.
// The register file is assumed to take file_wr on the clock edge after it rises.
// Contract
// - Store accumulator to file, one cycle, flags kept.
// - Load literal into accumulator, one cycle.
// - Interrupt return pops, loads PC, sets enable.
// - Literal return loads accumulator and PC, two cycles.
// - Subroutine exit pops into PC, two cycles.
`timescale 1ns/1ps
`default_nettype none
module cmr_core
    import cmr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [12:0] stack_top,
    output logic instr_ready,
    output logic stack_pop,
    output cmr_file_wr_t file_wr,
    output logic [7:0] acc,
    output logic [12:0] pc,
    output logic global_irq_enable,
    output logic [7:0] status_flags
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    typedef enum logic {CMR_FETCH, CMR_FLUSH} cmr_state_t;
    cmr_state_t state, next_state;
    cmr_op_t op;
    logic [7:0] next_acc;
    logic [12:0] next_pc;
    logic next_global_irq_enable;
    cmr_file_wr_t next_file_wr;

    // Decode the word; unknown words behave as idle so the PC never stalls.
    always_comb begin
        op = CMR_OP_IDLE;
        if (instr == OP_SUB_EXIT) begin
            op = CMR_OP_SUB_EXIT;
        end else if (instr == OP_IRQ_RET) begin
            op = CMR_OP_IRQ_RET;
        end else if (instr[OP_MSB:STORE_OPC_LSB] == OP_STORE_HI) begin
            // The low seven bits carry the file address.
            op = CMR_OP_STORE;
        end else if (instr[OP_MSB:LIT_OPC_LSB] == OP_LOAD_HI) begin
            // The low byte is the literal for both literal forms.
            op = CMR_OP_LOAD;
        end else if (instr[OP_MSB:LIT_OPC_LSB] == OP_LITRET_HI) begin
            op = CMR_OP_LIT_RET;
        end
    end

    // A return needs a second cycle to refill the fetch path.
    assign instr_ready = (state == CMR_FETCH);
    assign stack_pop = instr_ready && instr_valid &&
        (op == CMR_OP_SUB_EXIT || op == CMR_OP_IRQ_RET || op == CMR_OP_LIT_RET);
    // Flags are never touched by this subset.
    assign status_flags = FLAGS_RESET;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = CMR_FETCH;
        next_acc = acc;
        next_pc = pc;
        next_global_irq_enable = global_irq_enable;
        next_file_wr = '0;
        if (instr_ready && instr_valid) begin
            next_pc = pc + PC_STEP;
            unique case (op)
                CMR_OP_IDLE: begin
                end
                CMR_OP_STORE: begin
                    next_file_wr = '{we: 1'h1, addr: instr[FILE_ADDR_MSB:0], data: acc};
                end
                CMR_OP_LOAD: begin
                    next_acc = instr[LIT_MSB:0];
                end
                CMR_OP_SUB_EXIT: begin
                    next_pc = stack_top;
                    next_state = CMR_FLUSH;
                end
                CMR_OP_IRQ_RET: begin
                    next_pc = stack_top;
                    next_global_irq_enable = IRQ_EN_SET;
                    next_state = CMR_FLUSH;
                end
                CMR_OP_LIT_RET: begin
                    next_acc = instr[LIT_MSB:0];
                    next_pc = stack_top;
                    next_state = CMR_FLUSH;
                end
            endcase
        end
    end

    // Registers only; reset values are constants.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= CMR_FETCH;
            acc <= ACC_RESET;
            pc <= PC_RESET;
            global_irq_enable <= IRQ_EN_RESET;
            file_wr <= '0;
        end else begin
            state <= next_state;
            acc <= next_acc;
            pc <= next_pc;
            global_irq_enable <= next_global_irq_enable;
            file_wr <= next_file_wr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic take;
    logic [1:0] stall_run;
    logic [1:0] next_stall_run;
    assign take = instr_ready && instr_valid;

    // Count refused cycles in a row; a return may refuse one word, never a run of them.
    always_comb begin
        next_stall_run = '0;
        if (!instr_ready) begin
            next_stall_run = (stall_run == '1) ? stall_run : stall_run + 2'h1;
        end
    end

    // The count saturates, so a stuck stall can never wrap back into the legal range.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stall_run <= '0;
        end else begin
            stall_run <= next_stall_run;
        end
    end

    // Store: the word lands one cycle later, carrying the accumulator as it stood.
    a_store_write: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_STORE |=>
            file_wr.we && file_wr.data == $past(acc) && file_wr.addr == $past(instr[FILE_ADDR_MSB:0]))
        else $error("store did not write accumulator");

    // Store: the accumulator is only read, and the next word is taken at once.
    a_store_acc_kept: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_STORE |=> acc == $past(acc) && instr_ready)
        else $error("store changed accumulator or stalled");

    // Store: a single-cycle word never touches the return stack.
    a_store_no_pop: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_STORE |-> !stack_pop)
        else $error("store popped the stack");

    // Load: the literal reaches the accumulator and nothing is written to the file.
    a_load_literal: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_LOAD |=> acc == $past(instr[LIT_MSB:0]) && !file_wr.we)
        else $error("load literal wrong");

    // Load: one cycle, so the following word is accepted straight away.
    a_load_single: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_LOAD |-> !stack_pop ##1 instr_ready)
        else $error("load literal stalled or popped");

    // Interrupt return: pop, jump to the stack top and enable interrupts.
    a_irq_ret_pc: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_IRQ_RET |->
            stack_pop ##1 (pc == $past(stack_top) && global_irq_enable && !instr_ready))
        else $error("interrupt return wrong");

    // Every return lasts two cycles; a longer refusal would drop fetched words.
    a_return_two_cycles: assert property (@(posedge clk) disable iff (!rstn)
        stall_run <= RET_STALL_MAX)
        else $error("return stalled too long");

    // Literal return: literal into the accumulator, stack top into the PC, then fetch again.
    a_lit_ret: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_LIT_RET |=>
            acc == $past(instr[LIT_MSB:0]) && pc == $past(stack_top) ##1 instr_ready)
        else $error("literal return wrong");

    // Literal return: only the interrupt return may change the global enable.
    a_lit_ret_irq: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_LIT_RET |=> global_irq_enable == $past(global_irq_enable))
        else $error("literal return touched enable");

    // Subroutine exit: pop into the PC, refuse one word, then fetch again.
    a_sub_exit: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_SUB_EXIT |->
            stack_pop ##1 (!instr_ready && pc == $past(stack_top)) ##1 instr_ready)
        else $error("subroutine exit wrong");

    // Subroutine exit: the global enable is left as it was.
    a_sub_exit_irq: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_SUB_EXIT |=> global_irq_enable == $past(global_irq_enable))
        else $error("subroutine exit touched enable");

    // A pop always leads into the refill cycle of a return.
    a_pop_only_ret: assert property (@(posedge clk) disable iff (!rstn)
        stack_pop |=> !instr_ready)
        else $error("pop without return stall");

    // Idle: only the PC moves on by one word.
    a_idle_step: assert property (@(posedge clk) disable iff (!rstn)
        take && op == CMR_OP_IDLE |=> pc == $past(pc) + PC_STEP && acc == $past(acc) && !file_wr.we)
        else $error("idle changed state");

    // No word taken, whether stalled or not offered: PC, accumulator and enable hold and no file write is raised.
    a_hold_no_take: assert property (@(posedge clk) disable iff (!rstn)
        !take |=> pc == $past(pc) && acc == $past(acc) && !file_wr.we &&
            global_irq_enable == $past(global_irq_enable))
        else $error("state moved without a word");

    // No instruction of this subset alters a status flag.
    a_flags_still: assert property (@(posedge clk) disable iff (!rstn)
        ##1 $stable(status_flags))
        else $error("flags changed");

    // Main scenarios that the bench is expected to reach.
    c_store: cover property (@(posedge clk) disable iff (!rstn) take && op == CMR_OP_STORE);
    c_load: cover property (@(posedge clk) disable iff (!rstn) take && op == CMR_OP_LOAD);
    c_irq_ret: cover property (@(posedge clk) disable iff (!rstn) take && op == CMR_OP_IRQ_RET);
    c_sub_exit: cover property (@(posedge clk) disable iff (!rstn) take && op == CMR_OP_SUB_EXIT ##2 take);
    c_lit_ret: cover property (@(posedge clk) disable iff (!rstn) take && op == CMR_OP_LIT_RET ##2 take);
endmodule : cmr_core
`default_nettype wire

// ### hw/cmr_pkg.sv
// Package for the move and return instruction executor.
// Assumes a 14-bit instruction word and an 8-bit data path.
`default_nettype none
package cmr_pkg;
    // ------------------------------------------------------------
    // Instruction encodings
    // ------------------------------------------------------------
    localparam logic [13:0] OP_IDLE = 14'h0000;
    localparam logic [13:0] OP_SUB_EXIT = 14'h0008;
    localparam logic [13:0] OP_IRQ_RET = 14'h0009;
    localparam logic [6:0] OP_STORE_HI = 7'h01;
    localparam logic [5:0] OP_LOAD_HI = 6'h0c;
    localparam logic [5:0] OP_LITRET_HI = 6'h0d;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic IRQ_EN_RESET = 1'h0;
    localparam logic IRQ_EN_SET = 1'h1;
    // A return refuses exactly one word while the fetch path refills.
    localparam logic [1:0] RET_STALL_MAX = 2'h1;

    // ------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------
    localparam int OP_MSB = 13;
    localparam int STORE_OPC_LSB = 7;
    localparam int LIT_OPC_LSB = 8;
    localparam int FILE_ADDR_MSB = 6;
    localparam int LIT_MSB = 7;

    typedef enum logic [2:0] {
        CMR_OP_IDLE, CMR_OP_STORE, CMR_OP_LOAD, CMR_OP_SUB_EXIT, CMR_OP_IRQ_RET, CMR_OP_LIT_RET
    } cmr_op_t;

    // File write request towards the register file.
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } cmr_file_wr_t;
endpackage : cmr_pkg
`default_nettype wire

// ### test/cmr_core_test.sv
// Self-checking bench for the move and return executor.
// Assumes cmr_pkg encodings; inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module cmr_core_test;
    import cmr_pkg::*;
    logic clk = 0, rstn = 0, instr_valid = 0, instr_ready, stack_pop, irq_en, exp_irq_en;
    logic [13:0] instr = 14'h0000, w;
    logic [12:0] stack_top = 13'h0000, pc, epc;
    logic [7:0] acc, flags, eacc;
    logic [31:0] seed = 32'h65c8;
    cmr_file_wr_t file_wr;
    int errors = 0, n_tests = 0;
    logic [13:0] corner [9] = '{14'h0000, {OP_STORE_HI, 7'h00}, {OP_LOAD_HI, 8'hff}, {OP_STORE_HI, 7'h7f},
        {OP_LOAD_HI, 8'h00}, OP_SUB_EXIT, OP_IRQ_RET, {OP_LITRET_HI, 8'ha5}, {OP_STORE_HI, 7'h25}};
    always #12.5 clk = ~clk;
    cmr_core i_cmr_core(.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr), .stack_top(stack_top),
        .instr_ready(instr_ready), .stack_pop(stack_pop), .file_wr(file_wr), .acc(acc), .pc(pc),
        .global_irq_enable(irq_en), .status_flags(flags));
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xorshift
    function automatic logic is_ret(input logic [13:0] v);
        return v == OP_SUB_EXIT || v == OP_IRQ_RET || v[13:8] == OP_LITRET_HI;
    endfunction : is_ret
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // One instruction; the bench model is updated from the word itself, not the design.
    task automatic step(input logic [13:0] v, input logic [12:0] t);
        logic st;
        st = v[13:7] == OP_STORE_HI;
        instr_valid = 1;
        instr = v;
        stack_top = t;
        #1;
        check(stack_pop, is_ret(v), "pop");
        @(posedge clk);
        if (v[13:8] == OP_LOAD_HI || v[13:8] == OP_LITRET_HI) eacc = v[7:0];
        epc = is_ret(v) ? t : epc + PC_STEP;
        if (v == OP_IRQ_RET) exp_irq_en = 1'b1;
        @(negedge clk);
        check({acc, pc, irq_en}, {eacc, epc, exp_irq_en}, "state");
        check(file_wr.we, st, "write strobe");
        if (st) check(file_wr, {1'b1, v[6:0], eacc}, "write");
        check(flags, 8'h00, "flags");
        // The second cycle of a return must refuse a word still offered.
        if (is_ret(v)) begin
            instr = {OP_LOAD_HI, 8'h77};
            check(instr_ready, 1'b0, "stall");
            @(negedge clk);
            check({acc, pc}, {eacc, epc}, "refused");
        end
    endtask : step
    // ----------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1;
        check({acc, pc, irq_en, instr_ready}, {ACC_RESET, PC_RESET, 2'b01}, "reset");
        eacc = ACC_RESET;
        epc = PC_RESET;
        exp_irq_en = 1'b0;
        foreach (corner[i]) step(corner[i], 13'h1fff - 13'(i));
        $display("corner test done");
        // Mid-run reset: the enable set by the corner interrupt return must drop back.
        rstn = 0;
        instr_valid = 0;
        #1;
        check({acc, pc, irq_en, instr_ready}, {ACC_RESET, PC_RESET, IRQ_EN_RESET, 1'h1}, "mid reset");
        @(negedge clk);
        rstn = 1;
        eacc = ACC_RESET;
        epc = PC_RESET;
        exp_irq_en = IRQ_EN_RESET;
        repeat (300) begin
            seed = xorshift(seed);
            w = corner[seed[19:16] % 9];
            if (w[13:8] == OP_LOAD_HI || w[13:8] == OP_LITRET_HI) w[7:0] = seed[7:0];
            if (w[13:7] == OP_STORE_HI) w[6:0] = seed[6:0];
            if (seed[23:21] == 3'h0) w = seed[13:0];
            step(w, seed[31:19]);
            // A cycle with no word offered must leave the accumulator, PC and enable alone and raise no file write.
            if (seed[24]) begin
                instr_valid = 0;
                @(negedge clk);
                check({acc, pc, irq_en, file_wr.we}, {eacc, epc, exp_irq_en, 1'h0}, "bubble");
            end
        end
        $display("random test done");
        instr_valid = 0;
        complete_run();
    end
    // Three cycles per instruction at most, with a wide margin.
    initial begin
        #(25 * 3000);
        errors++;
        complete_run();
    end
endmodule : cmr_core_test
`default_nettype wire
